// ### design/vfm_pkg.sv
// Constants and types shared by the voice filter and channel mux
package vfm_pkg;
	// Register offsets on the register port
	localparam logic [6:0] VFM_REC_FILT_OFS = 7'h0c;
	localparam logic [6:0] VFM_PLAY_FILT_OFS = 7'h28;
	localparam logic [6:0] VFM_MUTE_OFS = 7'h30;
	// Reset values and writable bits
	localparam logic [7:0] VFM_FILT_RST = 8'h00;
	localparam logic [7:0] VFM_MUTE_RST = 8'h00;
	localparam logic [7:0] VFM_FILT_MASK = 8'h0f;
	localparam logic [7:0] VFM_MUTE_MASK = 8'h01;
	localparam logic [7:0] VFM_UNMAPPED = 8'h00;
	// Field positions
	localparam int VFM_LP_BIT = 3;
	localparam int VFM_DC_BIT = 2;
	localparam int VFM_HP_LSB = 0;
	localparam int VFM_MUTE_EN_BIT = 0;
	// Arithmetic formats
	localparam int VFM_SW = 16;
	localparam int VFM_GUARD = 8;
	localparam int VFM_CW = 24;
	localparam int VFM_CF = 22;
	localparam int VFM_NOISE_W = 5;
	localparam int VFM_FIFO_DEPTH = 8;
	localparam logic [15:0] VFM_LFSR_SEED = 16'hace1;
	// Corner select codes
	typedef enum logic [1:0] {
		VFM_HP_OFF = 2'h0,
		VFM_HP_LOW = 2'h1,
		VFM_HP_MID = 2'h2,
		VFM_HP_HIGH = 2'h3
	} vfm_hp_t;
	// Microphone routing codes
	typedef enum logic [1:0] {
		VFM_MIC_STRAIGHT = 2'h0,
		VFM_MIC_SWAP = 2'h1,
		VFM_MIC_DUP_L = 2'h2,
		VFM_MIC_DUP_R = 2'h3
	} vfm_mic_t;
	// Amplifier source codes, 3 also selects the mean
	typedef enum logic [1:0] {
		VFM_AMP_LEFT = 2'h0,
		VFM_AMP_RIGHT = 2'h1,
		VFM_AMP_MEAN = 2'h2
	} vfm_amp_t;
	// Record sequencer states
	typedef enum logic [2:0] {
		VFM_S_IDLE = 3'b001,
		VFM_S_RUN = 3'b010,
		VFM_S_PUSH = 3'b100
	} vfm_state_t;
endpackage

// ### design/vfm_fifo.sv
// Sample FIFO with a registered output word
`timescale 1ns/10ps
module vfm_fifo
	import vfm_pkg::*;
#(
	parameter int W = 32,
	parameter int DEPTH = VFM_FIFO_DEPTH
)(
	input wire logic clk_i, // Clock
	input wire logic rst_n_i, // Sync reset, low
	input wire logic in_valid_i, // Write request
	input wire logic [W-1:0] in_data_i, // Write word
	output logic in_ready_o, // Room for a word
	output logic out_valid_o, // Read word present
	output logic [W-1:0] out_data_o, // Read word
	input wire logic out_ready_i // Reader takes word
);
	localparam int AW = $clog2(DEPTH);
	// Depth must be a power of two of at least 2
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_chk
		$error("vfm_fifo depth unusable");
	end
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] cnt_q, cnt_d;
	logic push, load;

	assign push = in_valid_i && in_ready_o;
	assign load = (cnt_q != '0) && (!out_valid_o || out_ready_i);
	// Occupancy of the memory, excluding the output word
	always_comb
	begin
		cnt_d = cnt_q;
		if (push && !load)
			cnt_d = cnt_q + 1'b1;
		else if (load && !push)
			cnt_d = cnt_q - 1'b1;
	end
	// Storage
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wp_q] <= in_data_i;
	end
	// Pointers, count and full flag
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			in_ready_o <= 1'b0;
		end
		else
		begin
			wp_q <= wp_q + AW'(push);
			rp_q <= rp_q + AW'(load);
			cnt_q <= cnt_d;
			in_ready_o <= (cnt_d != (AW+1)'(DEPTH));
		end
	end
	// Output register
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end
		else if (load)
		begin
			out_valid_o <= 1'b1;
			out_data_o <= mem[rp_q];
		end
		else if (out_ready_i)
			out_valid_o <= 1'b0;
	end
endmodule // vfm_fifo

// ### design/vfm_biquad.sv
// One second-order IIR section with registered bypass
`timescale 1ns/10ps
module vfm_biquad
	import vfm_pkg::*;
#(
	parameter int DW = VFM_SW + VFM_GUARD
)(
	input wire logic clk_i, // Clock
	input wire logic rst_n_i, // Sync reset, low
	input wire logic in_valid_i, // New sample
	input wire logic signed [DW-1:0] x_i, // Sample in
	input wire logic bypass_i, // Pass sample through
	input wire logic signed [VFM_CW-1:0] b0_i, // Feed-forward 0
	input wire logic signed [VFM_CW-1:0] b1_i, // Feed-forward 1
	input wire logic signed [VFM_CW-1:0] b2_i, // Feed-forward 2
	input wire logic signed [VFM_CW-1:0] a1_i, // Feedback 1
	input wire logic signed [VFM_CW-1:0] a2_i, // Feedback 2
	output logic y_valid_o, // Result ready
	output logic signed [DW-1:0] y_o // Result
);
	localparam int AW = DW + VFM_CW + 3;
	localparam logic signed [AW-1:0] MAXV = AW'({1'b0, {(DW-1){1'b1}}});
	localparam logic signed [AW-1:0] MINV = -MAXV - 1;
	// State must hold at least a full sample word
	if (DW < VFM_SW)
	begin : g_chk
		$error("vfm_biquad width unusable");
	end
	logic signed [DW-1:0] x1_q, x2_q, y1_q, y2_q, y_d;
	logic signed [AW-1:0] acc, sh;

	// Direct form one sum, scaled back and clipped
	always_comb
	begin
		acc = AW'(x_i * b0_i) + AW'(x1_q * b1_i) + AW'(x2_q * b2_i)
			- AW'(y1_q * a1_i) - AW'(y2_q * a2_i);
		sh = acc >>> VFM_CF;
		if (sh > MAXV)
			y_d = MAXV[DW-1:0];
		else if (sh < MINV)
			y_d = MINV[DW-1:0];
		else
			y_d = sh[DW-1:0];
	end
	// History keeps running while bypassed
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			x1_q <= '0;
			x2_q <= '0;
			y1_q <= '0;
			y2_q <= '0;
			y_o <= '0;
			y_valid_o <= 1'b0;
		end
		else
		begin
			y_valid_o <= in_valid_i;
			if (in_valid_i)
			begin
				x1_q <= x_i;
				x2_q <= x1_q;
				y1_q <= y_d;
				y2_q <= y1_q;
				y_o <= bypass_i ? x_i : y_d;
			end
		end
	end
endmodule // vfm_biquad

// ### design/vfm_top.sv
// Voice filters, microphone and amplifier muxes, soft-mute noise
`timescale 1ns/10ps
// How it works
// - low-pass: Butterworth order four, corner 0.4375 fs
// - bit 3 inserts low-pass per path
// - DC blocker removes DC beyond 90dB
// - bit 2 inserts DC blocker per path
// - high-pass: Butterworth order four, three corners
// - select 0 off, then three fixed corners
// - bits 1:0 select, each path own register
// - both filter registers reset to zero
// - mic swap or duplicate, both mics on
// - amp takes left, right or mean
// - noise injected while muted and enabled
module vfm_top
	import vfm_pkg::*;
(
	input wire logic mclk_i, // 40 MHz clock
	input wire logic rst_n_i, // Sync reset, low
	input wire logic [6:0] reg_addr_i, // Register address
	input wire logic reg_wr_i, // Write strobe
	input wire logic [7:0] reg_wdata_i, // Write data
	input wire logic reg_rd_i, // Read strobe
	output logic [7:0] reg_rdata_o, // Read data
	input wire logic mic_l_on_i, // Left mic enabled
	input wire logic mic_r_on_i, // Right mic enabled
	input wire logic [1:0] mic_mux_sel_i, // Mic routing
	input wire logic [1:0] amp_mux_sel_i, // Amp source
	input wire logic vol_muted_i, // Playback volume muted
	input wire logic rec_valid_i, // Record sample in
	input wire logic [15:0] rec_l_i, // Left mic sample
	input wire logic [15:0] rec_r_i, // Right mic sample
	output logic rec_ready_o, // Record sample taken
	output logic rec_valid_o, // Record word out
	output logic [15:0] rec_l_o, // Left record out
	output logic [15:0] rec_r_o, // Right record out
	input wire logic rec_ready_i, // Reader takes word
	input wire logic play_valid_i, // Playback sample in
	input wire logic [15:0] play_l_i, // Playback left
	input wire logic [15:0] play_r_i, // Playback right
	output logic amp_valid_o, // Amp sample strobe
	output logic [15:0] amp_data_o // Amp sample
);
	localparam int DW = VFM_SW + VFM_GUARD;
	localparam int NCH = 3;
	localparam int NST = 5;
	localparam real ONE = real'(1 << VFM_CF);

	// Real to coefficient word, used only on constants
	function automatic logic signed [VFM_CW-1:0] cq(input real r);
		cq = VFM_CW'($rtoi(r * ONE));
	endfunction

	// Mean of two samples without overflow
	function automatic logic [15:0] mean16(
		input logic [15:0] a,
		input logic [15:0] b
	);
		logic signed [16:0] s;
		s = 17'(signed'(a)) + 17'(signed'(b));
		mean16 = s[16:1];
	endfunction

	// Low-pass sections {b0, a1, a2}, bilinear at 0.4375 fs
	localparam logic signed [VFM_CW-1:0] LPQ [2][3] = '{
		'{cq(0.710674), cq(1.365120), cq(0.477577)},
		'{cq(0.839051), cq(1.611738), cq(0.744467)}
	};
	// High-pass sections per corner 0.003125, 0.01875, 0.0375 fs
	localparam logic signed [VFM_CW-1:0] HPQ [3][2][3] = '{
		'{'{cq(0.982090), cq(-1.963993), cq(0.964457)},
		'{cq(0.992447), cq(-1.984703), cq(0.985086)}},
		'{'{cq(0.898921), cq(-1.791580), cq(0.804095)},
		'{cq(0.953640), cq(-1.900649), cq(0.913914)}},
		'{'{cq(0.811221), cq(-1.599714), cq(0.645174)},
		'{cq(0.905310), cq(-1.785252), cq(0.835983)}}
	};
	// DC blocker: zero at DC, pole at 1 - 2^-10
	localparam logic signed [VFM_CW-1:0] DC_B0 = cq(1.0);
	localparam logic signed [VFM_CW-1:0] DC_A1 = cq(-1.0 + 1.0 / 1024.0);

	// Configuration registers
	logic [7:0] rec_filt_q;
	logic [7:0] play_filt_q;
	logic [7:0] mute_cfg_q;
	// Record sequencer and output capture
	vfm_state_t state_q;
	logic push_valid_q;
	logic [31:0] push_data_q;
	logic fifo_ready;
	logic fifo_valid;
	logic [31:0] fifo_data;
	logic accept;
	// Playback noise
	logic [15:0] lfsr_q;
	// Filter chain wiring
	logic ch_valid [NCH];
	logic signed [DW-1:0] ch_x [NCH];
	logic st_valid [NCH][NST+1];
	logic signed [DW-1:0] st_data [NCH][NST+1];
	logic [15:0] ch_out [NCH];
	logic [15:0] play_mono;

	// Register writes, upper bits dropped
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			rec_filt_q <= VFM_FILT_RST;
			play_filt_q <= VFM_FILT_RST;
			mute_cfg_q <= VFM_MUTE_RST;
		end
		else if (reg_wr_i)
		begin
			case (reg_addr_i)
				VFM_REC_FILT_OFS:
					rec_filt_q <= reg_wdata_i & VFM_FILT_MASK;
				VFM_PLAY_FILT_OFS:
					play_filt_q <= reg_wdata_i & VFM_FILT_MASK;
				VFM_MUTE_OFS:
					mute_cfg_q <= reg_wdata_i & VFM_MUTE_MASK;
				default:
					;
			endcase
		end
	end

	// Register reads, answered one cycle after the strobe
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			reg_rdata_o <= VFM_UNMAPPED;
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				VFM_REC_FILT_OFS:
					reg_rdata_o <= rec_filt_q;
				VFM_PLAY_FILT_OFS:
					reg_rdata_o <= play_filt_q;
				VFM_MUTE_OFS:
					reg_rdata_o <= mute_cfg_q;
				default:
					reg_rdata_o <= VFM_UNMAPPED;
			endcase
		end
	end

	// Amplifier source selection
	always_comb
	begin
		case (amp_mux_sel_i)
			VFM_AMP_LEFT:
				play_mono = play_l_i;
			VFM_AMP_RIGHT:
				play_mono = play_r_i;
			default:
				play_mono = mean16(play_l_i, play_r_i);
		endcase
	end

	// Channel inputs widened with guard bits
	assign accept = rec_valid_i && rec_ready_o;
	assign ch_valid[0] = accept;
	assign ch_valid[1] = accept;
	assign ch_valid[2] = play_valid_i;
	assign ch_x[0] = {rec_l_i, {VFM_GUARD{1'b0}}};
	assign ch_x[1] = {rec_r_i, {VFM_GUARD{1'b0}}};
	assign ch_x[2] = {play_mono, {VFM_GUARD{1'b0}}};

	// Per channel: two low-pass, DC blocker, two high-pass
	for (genvar c = 0; c < NCH; c++)
	begin : g_ch
		logic [7:0] cfg;
		logic [1:0] hp;
		assign cfg = (c < 2) ? rec_filt_q : play_filt_q;
		assign hp = cfg[VFM_HP_LSB +: 2];
		assign st_valid[c][0] = ch_valid[c];
		assign st_data[c][0] = ch_x[c];
		assign ch_out[c] = st_data[c][NST][DW-1 -: VFM_SW];
		for (genvar s = 0; s < NST; s++)
		begin : g_st
			logic signed [VFM_CW-1:0] b0, b1, b2, a1, a2;
			logic byp;
			// Section coefficients and bypass
			always_comb
			begin
				if (s < 2)
				begin
					b0 = LPQ[s % 2][0];
					b1 = b0 <<< 1;
					b2 = b0;
					a1 = LPQ[s % 2][1];
					a2 = LPQ[s % 2][2];
					byp = !cfg[VFM_LP_BIT];
				end
				else if (s == 2)
				begin
					b0 = DC_B0;
					b1 = -DC_B0;
					b2 = '0;
					a1 = DC_A1;
					a2 = '0;
					byp = !cfg[VFM_DC_BIT];
				end
				else
				begin
					b0 = HPQ[(hp == 2'h0) ? 0 : hp - 2'h1][s % 2][0];
					b1 = -(b0 <<< 1);
					b2 = b0;
					a1 = HPQ[(hp == 2'h0) ? 0 : hp - 2'h1][s % 2][1];
					a2 = HPQ[(hp == 2'h0) ? 0 : hp - 2'h1][s % 2][2];
					byp = (hp == VFM_HP_OFF);
				end
			end
			vfm_biquad #(
				.DW(DW)
			) u_sec (
				.clk_i(mclk_i),
				.rst_n_i(rst_n_i),
				.in_valid_i(st_valid[c][s]),
				.x_i(st_data[c][s]),
				.bypass_i(byp),
				.b0_i(b0),
				.b1_i(b1),
				.b2_i(b2),
				.a1_i(a1),
				.a2_i(a2),
				.y_valid_o(st_valid[c][s+1]),
				.y_o(st_data[c][s+1])
			);
		end
	end

	// Record sequencer: one sample in flight at a time
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			state_q <= VFM_S_IDLE;
		else
		begin
			case (state_q)
				VFM_S_IDLE:
					if (accept)
						state_q <= VFM_S_RUN;
				VFM_S_RUN:
					if (st_valid[0][NST])
						state_q <= VFM_S_PUSH;
				VFM_S_PUSH:
					if (fifo_ready)
						state_q <= VFM_S_IDLE;
				default:
					state_q <= VFM_S_IDLE;
			endcase
		end
	end

	// Input ready only when idle and the FIFO has room
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			rec_ready_o <= 1'b0;
		else
			rec_ready_o <= (state_q == VFM_S_IDLE) && !accept && fifo_ready;
	end

	// Microphone routing, active only with both mics on
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			push_valid_q <= 1'b0;
			push_data_q <= '0;
		end
		else if (state_q == VFM_S_RUN && st_valid[0][NST])
		begin
			push_valid_q <= 1'b1;
			if (!(mic_l_on_i && mic_r_on_i))
				push_data_q <= {ch_out[0], ch_out[1]};
			else
			begin
				case (mic_mux_sel_i)
					VFM_MIC_SWAP:
						push_data_q <= {ch_out[1], ch_out[0]};
					VFM_MIC_DUP_L:
						push_data_q <= {ch_out[0], ch_out[0]};
					VFM_MIC_DUP_R:
						push_data_q <= {ch_out[1], ch_out[1]};
					default:
						push_data_q <= {ch_out[0], ch_out[1]};
				endcase
			end
		end
		else if (fifo_ready)
			push_valid_q <= 1'b0;
	end

	vfm_fifo #(
		.W(32),
		.DEPTH(VFM_FIFO_DEPTH)
	) u_fifo (
		.clk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(push_valid_q),
		.in_data_i(push_data_q),
		.in_ready_o(fifo_ready),
		.out_valid_o(fifo_valid),
		.out_data_o(fifo_data),
		.out_ready_i(rec_ready_i)
	);

	// FIFO output is already registered
	assign rec_valid_o = fifo_valid;
	assign rec_l_o = fifo_data[31:16];
	assign rec_r_o = fifo_data[15:0];

	// Noise source steps once per playback sample
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			lfsr_q <= VFM_LFSR_SEED;
		else if (st_valid[2][NST])
			lfsr_q <= {lfsr_q[14:0],
				lfsr_q[15] ^ lfsr_q[14] ^ lfsr_q[12] ^ lfsr_q[3]};
	end

	// Amplifier output with optional soft-mute noise
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			amp_valid_o <= 1'b0;
			amp_data_o <= '0;
		end
		else
		begin
			amp_valid_o <= st_valid[2][NST];
			if (st_valid[2][NST])
			begin
				if (mute_cfg_q[VFM_MUTE_EN_BIT] && vol_muted_i)
					amp_data_o <= ch_out[2] + 16'(signed'(
						lfsr_q[VFM_NOISE_W-1:0]));
				else
					amp_data_o <= ch_out[2];
			end
		end
	end
endmodule // vfm_top

// ### testbench/vfm_top_checker.sv
// Port assertions for the voice filter top level
`timescale 1ns/10ps
module vfm_top_checker
	import vfm_pkg::*;
(
	input wire logic mclk_i, // Clock
	input wire logic rst_n_i, // Reset, low
	input wire logic [6:0] reg_addr_i, // Address
	input wire logic reg_wr_i, // Write
	input wire logic [7:0] reg_wdata_i, // Write data
	input wire logic reg_rd_i, // Read
	input wire logic [7:0] reg_rdata_o, // Read data
	input wire logic rec_valid_i, // Record offer
	input wire logic rec_ready_o, // Record take
	input wire logic rec_valid_o, // Head valid
	input wire logic [15:0] rec_l_o, // Head left
	input wire logic [15:0] rec_r_o, // Head right
	input wire logic rec_ready_i, // Reader
	input wire logic play_valid_i, // Playback in
	input wire logic amp_valid_o, // Amp strobe
	input wire logic [15:0] amp_data_o // Amp sample
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	// Address decode
	wire filt_w = reg_addr_i == VFM_REC_FILT_OFS ||
		reg_addr_i == VFM_PLAY_FILT_OFS;
	wire map_w = filt_w || reg_addr_i == VFM_MUTE_OFS;
	// Write then read back of the record register
	sequence s_wr_rec;
		reg_wr_i && reg_addr_i == VFM_REC_FILT_OFS;
	endsequence
	sequence s_rd_rec;
		reg_rd_i && !reg_wr_i && reg_addr_i == VFM_REC_FILT_OFS;
	endsequence
	wr_readback_a: assert property (s_wr_rec ##1 s_rd_rec |=>
		reg_rdata_o == ($past(reg_wdata_i, 2) & VFM_FILT_MASK))
		else $error("read back differs from masked write");
	rd_unmapped_a: assert property (reg_rd_i && !map_w |=>
		reg_rdata_o == VFM_UNMAPPED) else $error("unmapped read");
	rd_upper_a: assert property (reg_rd_i && filt_w |=>
		reg_rdata_o[7:4] == 4'h0) else $error("upper bits set");
	rd_mute_a: assert property (reg_rd_i && !filt_w && map_w |=>
		reg_rdata_o[7:1] == 7'h00) else $error("mute bits set");
	rd_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved");
	amp_latency_a: assert property (play_valid_i |-> ##6 amp_valid_o)
		else $error("amp strobe late");
	amp_source_a: assert property (amp_valid_o |->
		$past(play_valid_i, 6)) else $error("amp strobe unasked");
	amp_hold_a: assert property (!amp_valid_o |-> $stable(amp_data_o))
		else $error("amp data moved");
	take_drop_a: assert property (rec_valid_i && rec_ready_o |=>
		!rec_ready_o) else $error("ready held after take");
	head_hold_a: assert property (rec_valid_o && !rec_ready_i |=>
		rec_valid_o && $stable(rec_l_o) && $stable(rec_r_o))
		else $error("head changed while stalled");
endmodule // vfm_top_checker
bind vfm_top vfm_top_checker u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
	.reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .rec_valid_i(rec_valid_i),
	.rec_ready_o(rec_ready_o), .rec_valid_o(rec_valid_o),
	.rec_l_o(rec_l_o), .rec_r_o(rec_r_o), .rec_ready_i(rec_ready_i),
	.play_valid_i(play_valid_i), .amp_valid_o(amp_valid_o),
	.amp_data_o(amp_data_o));

// ### testbench/tb_voice_filter_and_channel_mux.sv
// Self-checking bench for the voice filter and channel mux
`timescale 1ns/10ps
`define CHK(a, b) chk((a) === (b), 32'(a), 32'(b))
module tb_voice_filter_and_channel_mux;
	import vfm_pkg::*;
	logic mclk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
	logic [6:0] reg_addr_i = '0;
	logic [7:0] reg_wdata_i = '0, reg_rdata_o;
	logic mic_l_on_i = 0, mic_r_on_i = 0, vol_muted_i = 0, tk;
	logic [1:0] mic_mux_sel_i = '0, amp_mux_sel_i = '0;
	logic rec_valid_i = 0, rec_ready_i = 0, play_valid_i = 0;
	logic [15:0] rec_l_i = '0, rec_r_i = '0, play_l_i = '0, play_r_i = '0;
	logic rec_ready_o, rec_valid_o, amp_valid_o;
	logic [15:0] rec_l_o, rec_r_o, amp_data_o, got;
	logic [31:0] seed = 32'h387b3b3f;
	logic [31:0] exp_q [$];
	int n_errors = 0, check_count = 0;
	// Clock
	always #12.5 mclk_i = ~mclk_i;
	vfm_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .mic_l_on_i(mic_l_on_i),
		.mic_r_on_i(mic_r_on_i), .mic_mux_sel_i(mic_mux_sel_i),
		.amp_mux_sel_i(amp_mux_sel_i), .vol_muted_i(vol_muted_i),
		.rec_valid_i(rec_valid_i), .rec_l_i(rec_l_i), .rec_r_i(rec_r_i),
		.rec_ready_o(rec_ready_o), .rec_valid_o(rec_valid_o),
		.rec_l_o(rec_l_o), .rec_r_o(rec_r_o), .rec_ready_i(rec_ready_i),
		.play_valid_i(play_valid_i), .play_l_i(play_l_i),
		.play_r_i(play_r_i), .amp_valid_o(amp_valid_o),
		.amp_data_o(amp_data_o));
	// Compare and count
	task automatic chk(input logic ok, input logic [31:0] g, e);
		check_count++;
		if (!ok)
		begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic hang();
		n_errors++;
		$display("[FAIL] %0t timeout", $time);
		close_out();
	endtask
	// Random source
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] amp_exp(input logic [1:0] m,
		input logic [15:0] l, r);
		logic [16:0] s;
		s = {l[15], l} + {r[15], r};
		return m == 2'h0 ? l : m == 2'h1 ? r : s[16:1];
	endfunction
	function automatic logic [31:0] mic_exp(input logic [15:0] l, r);
		if (!(mic_l_on_i && mic_r_on_i))
			return {l, r};
		case (mic_mux_sel_i)
			VFM_MIC_SWAP: return {r, l};
			VFM_MIC_DUP_L: return {l, l};
			VFM_MIC_DUP_R: return {r, r};
			default: return {l, r};
		endcase
	endfunction
	// Bus and stream drivers, all start 2 ns after an edge
	task automatic tick();
		@(posedge mclk_i);
		#2;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1;
		tick();
		reg_wr_i = 0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		reg_addr_i = a;
		reg_rd_i = 1;
		tick();
		reg_rd_i = 0;
		`CHK(reg_rdata_o, e);
		// Let an edge pass before the next strobe
		tick();
	endtask
	task automatic play(input logic [15:0] l, r);
		int i;
		play_l_i = l;
		play_r_i = r;
		play_valid_i = 1;
		tick();
		play_valid_i = 0;
		for (i = 0; i < 10 && !amp_valid_o; i++)
			tick();
		if (!amp_valid_o)
			hang();
		got = amp_data_o;
	endtask
	task automatic push(input logic [15:0] l, r, input int lim);
		int i;
		rec_l_i = l;
		rec_r_i = r;
		rec_valid_i = 1;
		tk = 0;
		for (i = 0; i < lim && !tk; i++)
		begin
			tk = rec_ready_o;
			tick();
		end
		rec_valid_i = 0;
		tick();
	endtask
	task automatic pop(input logic [31:0] e);
		int i;
		for (i = 0; i < 40 && !rec_valid_o; i++)
			tick();
		if (!rec_valid_o)
			hang();
		`CHK({rec_l_o, rec_r_o}, e);
		rec_ready_i = 1;
		tick();
		rec_ready_i = 0;
		tick();
	endtask
	// Hang guard
	initial
	begin
		repeat (100000) @(posedge mclk_i);
		hang();
	end
	// Main sequence
	initial
	begin
		int i, k;
		logic [15:0] e;
		logic signed [15:0] s;
		repeat (12) @(posedge mclk_i);
		#2;
		rst_n_i = 1;
		tick();
		rd(VFM_REC_FILT_OFS, 8'h00);
		rd(VFM_PLAY_FILT_OFS, 8'h00);
		rd(VFM_MUTE_OFS, 8'h00);
		rd(7'h0d, VFM_UNMAPPED);
		// Random writes read back with upper bits dropped
		for (i = 0; i < 6; i++)
		begin
			seed = nxt(seed);
			wr(VFM_REC_FILT_OFS, seed[7:0]);
			rd(VFM_REC_FILT_OFS, {4'h0, seed[3:0]});
		end
		wr(VFM_PLAY_FILT_OFS, 8'hf0);
		rd(VFM_PLAY_FILT_OFS, 8'h00);
		wr(VFM_MUTE_OFS, 8'hff);
		rd(VFM_MUTE_OFS, 8'h01);
		wr(VFM_MUTE_OFS, 8'h00);
		tick();
		wr(VFM_REC_FILT_OFS, 8'h00);
		// Bypassed playback through every amp source
		for (i = 0; i < 16; i++)
		begin
			seed = nxt(seed);
			amp_mux_sel_i = i[1:0];
			e = i < 4 ? 16'h7fff : seed[31:16];
			play(e, seed[15:0]);
			`CHK(got, amp_exp(i[1:0], e, seed[15:0]));
		end
		// Record routing, playback filters on
		wr(VFM_PLAY_FILT_OFS, 8'h0f);
		for (i = 0; i < 16; i++)
		begin
			seed = nxt(seed);
			mic_mux_sel_i = i[1:0];
			{mic_l_on_i, mic_r_on_i} = i < 12 ? 2'b11 : 2'b10;
			push(seed[31:16], seed[15:0], 40);
			pop(mic_exp(seed[31:16], seed[15:0]));
		end
		// Fill the buffer until refused, then drain in order
		mic_mux_sel_i = VFM_MIC_STRAIGHT;
		for (i = 0; i < 10; i++)
		begin
			seed = nxt(seed);
			push(seed[31:16], seed[15:0], 60);
			if (tk)
				exp_q.push_back(seed);
		end
		`CHK(exp_q.size(), VFM_FIFO_DEPTH + 1);
		while (exp_q.size() > 0)
			pop(exp_q.pop_front());
		// Noise only when enabled and muted
		wr(VFM_PLAY_FILT_OFS, 8'h00);
		tick();
		amp_mux_sel_i = VFM_AMP_LEFT;
		for (k = 0; k < 3; k++)
		begin
			wr(VFM_MUTE_OFS, {7'h00, k != 1});
			vol_muted_i = k < 2;
			e = '0;
			for (i = 0; i < 16; i++)
			begin
				play(16'h0000, 16'h0000);
				s = got;
				`CHK(s >= -16 && s <= 15, 1'b1);
				e = e | got;
			end
			`CHK(e != 0, k == 0);
		end
		vol_muted_i = 0;
		// Low-pass kills fs/2, DC blocker and high-pass kill DC
		for (k = 0; k < 3; k++)
		begin
			wr(VFM_PLAY_FILT_OFS, k == 2 ? 8'h03 : 8'h08 >> k);
			// DC blocker pole needs about 5000 samples to settle
			for (i = 0; i < (k == 1 ? 6000 : 300); i++)
				play(k == 0 && i[0] ? 16'he0c0 : 16'h1f40, 16'h0000);
			s = got;
			`CHK(s > -64 && s < 64, 1'b1);
		end
		close_out();
	end
endmodule // tb_voice_filter_and_channel_mux
